// file: rtl/sat_regs.svh
`ifndef SAT_REGS_SVH
`define SAT_REGS_SVH

// register byte addresses
`define SAT_MODE_ADDR      8'h00
`define SAT_AUDIO_ADDR     8'h04
`define SAT_AGC_ADDR       8'h08
`define SAT_SCR_ADDR       8'h0c
`define SAT_TDEC_ADDR      8'h10
`define SAT_GAIN_ADDR      8'h14
`define SAT_STAT_ADDR      8'h18
`define SAT_TONE_ADDR      8'h1c

// mode control fields
`define SAT_MODE_TONE_EN   0
`define SAT_MODE_CODE_EN   1
`define SAT_MODE_TX_EN     2
`define SAT_MODE_CODE24    3
`define SAT_MODE_MOD_INV   4
`define SAT_MODE_COMP_EN   5
`define SAT_MODE_EXP_EN    6
`define SAT_MODE_SCR_EN    7
`define SAT_MODE_BURST     8
`define SAT_MODE_W         9

// audio control fields
`define SAT_AUD_SEL_MSB    7
`define SAT_AUD_PHASE      8

// agc setup entry fields
`define SAT_AGC_EN         0
`define SAT_AGC_SRC        1
`define SAT_AGC_RATE_LSB   4
`define SAT_AGC_RATE_MSB   7
`define SAT_AGC_THR_LSB    8
`define SAT_AGC_THR_MSB    15

// tone decoder setup entry fields
`define SAT_TDEC_BW_MSB    3
`define SAT_TDEC_THR_LSB   4
`define SAT_TDEC_THR_MSB   11

// status bits
`define SAT_STAT_TONE      11
`define SAT_TONE_PHASE     9

// reset values
`define SAT_SCR_RESET      16'h0ce4
`define SAT_GAIN_RESET     4'h0

// selection values
`define SAT_SEL_NONE       8'h00
`define SAT_SEL_DCS_LAST   8'h53
`define SAT_SEL_DCS_USER   8'h54
`define SAT_SEL_INV_FIRST  8'h65
`define SAT_SEL_INV_LAST   8'hb7
`define SAT_SEL_INV_USER   8'hb8
`define SAT_SEL_LEARN      8'hc8
`define SAT_SEL_TONE_FIRST 8'hc9
`define SAT_SEL_TONE_LAST  8'hfe
`define SAT_SEL_INVALID    8'hff
`define SAT_SEL_ALL_CALL   8'hf0

`endif

// file: rtl/sat_pkg.sv
package sat_pkg;
   // meaning of the tone/code selection field
   typedef enum logic [2:0] {
      SAT_SEL_OFF,
      SAT_SEL_CODE,
      SAT_SEL_CODE_INV,
      SAT_SEL_LEARN,
      SAT_SEL_TONE,
      SAT_SEL_BAD
   } sat_sel_type;

   // input gain control state
   typedef enum logic [1:0] {
      SAT_AGC_IDLE,
      SAT_AGC_TRACK
   } sat_agc_type;
endpackage : sat_pkg

// file: rtl/sat_audio_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "sat_regs.svh"
// How it works
// - input gain control runs only when its enable bit in agc setup is set
// - tx entry captures gain; above threshold gain steps down until in range or minimum
// - below threshold gain steps up at the set rate until captured gain returns
// - detector source bit picks gain stage output or pre-emphasis output
// - compressor follows average envelope; output changes half the input dB change
// - expander applies the inverse law on the average envelope
// - scrambler inversion frequency resets to 3300 Hz and is writable
// - selection is low byte of audio control; zero means no tone or code
// - 1-83 codes, 84 user code, 101-183 inverted, 184 inverted user
// - 200 learn mode, 201-254 tones, 255 invalid tone
// - learn mode reports whichever continuous tone is received
// - separate mode bits enable tone and code without touching selection
// - code path supports 23/24-bit, true/inverted, and 134 Hz turn-off burst
// - reverse burst by modulator inversion or audio control phase bit
// - valid tone detected sets main status bit 11
// - detector bandwidth/threshold from decoder setup; wanted tone from selection
// - phase shift of 90 degrees sets tone status bit 9 and main bit 11
// - tone status low byte zero means no tone detected
// - selection zero with tones enabled scans only for all-call tone 240
// - outside learn mode, a tone matching neither selection nor all-call reports 255
module sat_audio_ctrl #(
   parameter int unsigned SAMPLE_HZ = 8000, // audio sample rate
   parameter int unsigned ENV_SHIFT = 6,    // syllabic time constant as a shift
   parameter int unsigned NOM_MSB   = 12    // envelope msb left unchanged by companding
) (
   input  wire logic        core_clk_in,
   input  wire logic        rst_b_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [15:0] rdata_out,
   input  wire logic        sample_valid_in,
   input  wire logic [15:0] gain_stage_in,
   input  wire logic [15:0] preemph_in,
   input  wire logic [15:0] rx_audio_in,
   output logic      [15:0] tx_audio_out,
   output logic      [15:0] rx_audio_out,
   output logic             audio_valid_out,
   output logic      [3:0]  input_gain_out,
   input  wire logic        tone_valid_in,
   input  wire logic [7:0]  tone_rx_in,
   input  wire logic        phase_shift_in,
   output logic      [3:0]  tone_bw_out,
   output logic      [7:0]  tone_thr_out,
   output logic      [7:0]  wanted_tone_out,
   output logic             tone_learn_out,
   output logic             code_en_out,
   output logic      [7:0]  code_sel_out,
   output logic             code_invert_out,
   output logic             code_24bit_out,
   output logic             code_burst_out,
   output logic             tone_phase_inv_out,
   output logic             modulator_output_one_inv_out,
   output logic             modulator_output_two_inv_out
);

   // most significant set bit of a magnitude
   function automatic logic [3:0] msb_pos(input logic [15:0] v);
      msb_pos = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (v[i]) begin
            msb_pos = 4'(i);
         end
      end
   endfunction : msb_pos

   // absolute value, clipped so the most negative sample stays positive
   function automatic logic [15:0] mag(input logic [15:0] s);
      mag = s[15] ? ((s == 16'h8000) ? 16'h7fff : 16'(-s)) : s;
   endfunction : mag

   // shift a sample left (positive) or right (negative) arithmetically
   function automatic logic [15:0] scale(input logic [15:0] s, input logic signed [5:0] sh);
      scale = (sh >= 0) ? 16'($signed(s) <<< sh) : 16'($signed(s) >>> (-sh));
   endfunction : scale

   // classify the selection field
   function automatic sat_pkg::sat_sel_type sel_class(input logic [7:0] v);
      if (v == `SAT_SEL_NONE)                                    sel_class = sat_pkg::SAT_SEL_OFF;
      else if (v <= `SAT_SEL_DCS_USER)                           sel_class = sat_pkg::SAT_SEL_CODE;
      else if (v >= `SAT_SEL_INV_FIRST && v <= `SAT_SEL_INV_USER) sel_class = sat_pkg::SAT_SEL_CODE_INV;
      else if (v == `SAT_SEL_LEARN)                              sel_class = sat_pkg::SAT_SEL_LEARN;
      else if (v >= `SAT_SEL_TONE_FIRST && v <= `SAT_SEL_TONE_LAST) sel_class = sat_pkg::SAT_SEL_TONE;
      else                                                       sel_class = sat_pkg::SAT_SEL_BAD;
   endfunction : sel_class

   logic [`SAT_MODE_W-1:0] mode_reg;
   logic [8:0]             audio_reg;
   logic [15:0]            agc_cfg_reg;
   logic [15:0]            scr_freq_reg;
   logic [11:0]            tdec_reg;
   logic [3:0]             gain_host_reg;
   logic [3:0]             gain_init_reg;
   logic [3:0]             gain_reg;
   logic [3:0]             rate_cnt_reg;
   logic                   tx_prev_reg;
   sat_pkg::sat_agc_type   agc_state_reg;
   logic [15:0]            env_tx_reg;
   logic [15:0]            env_rx_reg;
   logic [16:0]            scr_acc_reg;
   logic                   scr_sign_reg;
   logic [7:0]             tone_stat_reg;
   logic                   phase_flag_reg;
   logic                   rd_tone_reg;
   sat_pkg::sat_sel_type   sel_kind;
   logic [7:0]             sel;
   logic [15:0]            det_mag;
   logic                   over_thr;
   logic [15:0]            comp_s;
   logic [16:0]            scr_acc_next;
   logic [7:0]             tone_stat_next;
   logic [15:0]            rdata_next;
   logic [15:0]            mode_full;
   logic [15:0]            stat_word;

   assign sel      = audio_reg[`SAT_AUD_SEL_MSB:0];
   assign sel_kind = sel_class(sel);

   // software writes to the control registers
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         mode_reg      <= '0;
         audio_reg     <= '0;
         agc_cfg_reg   <= '0;
         scr_freq_reg  <= `SAT_SCR_RESET;
         tdec_reg      <= '0;
         gain_host_reg <= `SAT_GAIN_RESET;
      end else if (wr_in) begin
         unique case (addr_in)
            `SAT_MODE_ADDR:  mode_reg      <= wdata_in[`SAT_MODE_W-1:0];
            `SAT_AUDIO_ADDR: audio_reg     <= wdata_in[8:0];
            `SAT_AGC_ADDR:   agc_cfg_reg   <= wdata_in;
            `SAT_SCR_ADDR:   scr_freq_reg  <= wdata_in;
            `SAT_TDEC_ADDR:  tdec_reg      <= wdata_in[11:0];
            `SAT_GAIN_ADDR:  gain_host_reg <= wdata_in[3:0];
            default: ;
         endcase
      end
   end

   // level detector source and threshold test
   assign det_mag  = mag(agc_cfg_reg[`SAT_AGC_SRC] ? preemph_in : gain_stage_in);
   assign over_thr = det_mag[14:7] > agc_cfg_reg[`SAT_AGC_THR_MSB:`SAT_AGC_THR_LSB];

   // input gain control: capture on tx entry, step down fast, step up at rate
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         agc_state_reg <= sat_pkg::SAT_AGC_IDLE;
         gain_reg      <= '0;
         gain_init_reg <= '0;
         rate_cnt_reg  <= '0;
         tx_prev_reg   <= 1'b0;
      end else begin
         tx_prev_reg <= mode_reg[`SAT_MODE_TX_EN];
         unique case (agc_state_reg)
            sat_pkg::SAT_AGC_IDLE: begin
               gain_reg <= gain_host_reg;
               if (agc_cfg_reg[`SAT_AGC_EN] && mode_reg[`SAT_MODE_TX_EN] && !tx_prev_reg) begin
                  gain_init_reg <= gain_host_reg;
                  agc_state_reg <= sat_pkg::SAT_AGC_TRACK;
                  rate_cnt_reg  <= '0;
               end
            end
            sat_pkg::SAT_AGC_TRACK: begin
               if (!agc_cfg_reg[`SAT_AGC_EN] || !mode_reg[`SAT_MODE_TX_EN]) begin
                  agc_state_reg <= sat_pkg::SAT_AGC_IDLE;
               end else if (sample_valid_in) begin
                  if (over_thr) begin
                     rate_cnt_reg <= '0;
                     if (gain_reg != '0) begin
                        gain_reg <= gain_reg - 4'h1;
                     end
                  end else if (gain_reg != gain_init_reg) begin
                     if (rate_cnt_reg >= agc_cfg_reg[`SAT_AGC_RATE_MSB:`SAT_AGC_RATE_LSB]) begin
                        rate_cnt_reg <= '0;
                        gain_reg     <= gain_reg + 4'h1;
                     end else begin
                        rate_cnt_reg <= rate_cnt_reg + 4'h1;
                     end
                  end
               end
            end
         endcase
      end
   end

   assign input_gain_out = gain_reg;

   // syllabic envelope followers for compressor and expander
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         env_tx_reg <= '0;
         env_rx_reg <= '0;
      end else if (sample_valid_in) begin
         env_tx_reg <= 16'($signed({1'b0, env_tx_reg})
                      + (($signed({1'b0, mag(gain_stage_in)}) - $signed({1'b0, env_tx_reg}))
                         >>> ENV_SHIFT));
         env_rx_reg <= 16'($signed({1'b0, env_rx_reg})
                      + (($signed({1'b0, mag(rx_audio_in)}) - $signed({1'b0, env_rx_reg}))
                         >>> ENV_SHIFT));
      end
   end

   // compressor halves, expander doubles the envelope's log change
   assign comp_s = mode_reg[`SAT_MODE_COMP_EN]
                   ? scale(gain_stage_in,
                           6'(($signed({2'b00, 4'(NOM_MSB)}) - $signed({2'b00, msb_pos(env_tx_reg)})) >>> 1))
                   : gain_stage_in;

   // square-carrier inversion with programmable frequency
   assign scr_acc_next = scr_acc_reg + {scr_freq_reg, 1'b0};

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         scr_acc_reg  <= '0;
         scr_sign_reg <= 1'b0;
      end else if (sample_valid_in) begin
         if (scr_acc_next >= 17'(SAMPLE_HZ)) begin
            scr_acc_reg  <= scr_acc_next - 17'(SAMPLE_HZ);
            scr_sign_reg <= !scr_sign_reg;
         end else begin
            scr_acc_reg <= scr_acc_next;
         end
      end
   end

   // registered audio outputs
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         tx_audio_out    <= '0;
         rx_audio_out    <= '0;
         audio_valid_out <= 1'b0;
      end else begin
         audio_valid_out <= sample_valid_in;
         if (sample_valid_in) begin
            tx_audio_out <= (mode_reg[`SAT_MODE_SCR_EN] && scr_sign_reg) ? 16'(-comp_s) : comp_s;
            rx_audio_out <= mode_reg[`SAT_MODE_EXP_EN]
                            ? scale(rx_audio_in,
                                    6'($signed({2'b00, msb_pos(env_rx_reg)}) - $signed({2'b00, 4'(NOM_MSB)})))
                            : rx_audio_in;
         end
      end
   end

   // tone status value from what the detector reports
   always_comb begin
      tone_stat_next = tone_stat_reg;
      if (!mode_reg[`SAT_MODE_TONE_EN]) begin
         tone_stat_next = `SAT_SEL_NONE;
      end else if (tone_valid_in) begin
         if (tone_rx_in == `SAT_SEL_NONE) begin
            tone_stat_next = `SAT_SEL_NONE;
         end else if (sel_kind == sat_pkg::SAT_SEL_LEARN) begin
            tone_stat_next = tone_rx_in;
         end else if (tone_rx_in == `SAT_SEL_ALL_CALL) begin
            tone_stat_next = tone_rx_in;
         end else if (tone_rx_in == sel && sel_kind == sat_pkg::SAT_SEL_TONE) begin
            tone_stat_next = tone_rx_in;
         end else begin
            tone_stat_next = `SAT_SEL_INVALID;
         end
      end
   end

   // tone status and phase flag; a new phase event wins over the read clear
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         tone_stat_reg  <= '0;
         phase_flag_reg <= 1'b0;
         rd_tone_reg    <= 1'b0;
      end else begin
         tone_stat_reg <= tone_stat_next;
         rd_tone_reg   <= rd_in && addr_in == `SAT_TONE_ADDR;
         if (phase_shift_in && mode_reg[`SAT_MODE_TONE_EN]) begin
            phase_flag_reg <= 1'b1;
         end else if (rd_tone_reg) begin
            phase_flag_reg <= 1'b0;
         end
      end
   end

   // main status bit: valid own, all-call or learned tone, or phase event
   always_comb begin
      stat_word = '0;
      stat_word[`SAT_STAT_TONE] = phase_flag_reg
                                  || (tone_stat_reg != `SAT_SEL_NONE
                                      && tone_stat_reg != `SAT_SEL_INVALID);
   end

   assign mode_full = 16'(mode_reg);

   // register read mux, data stand in the cycle after the strobe
   always_comb begin
      rdata_next = '0;
      unique case (addr_in)
         `SAT_MODE_ADDR:  rdata_next = mode_full;
         `SAT_AUDIO_ADDR: rdata_next = 16'(audio_reg);
         `SAT_AGC_ADDR:   rdata_next = agc_cfg_reg;
         `SAT_SCR_ADDR:   rdata_next = scr_freq_reg;
         `SAT_TDEC_ADDR:  rdata_next = 16'(tdec_reg);
         `SAT_GAIN_ADDR:  rdata_next = 16'(gain_reg);
         `SAT_STAT_ADDR:  rdata_next = stat_word;
         `SAT_TONE_ADDR:  rdata_next = {6'h00, phase_flag_reg, 1'b0, tone_stat_reg};
         default:         rdata_next = '0;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= rd_in ? rdata_next : '0;
      end
   end

   // detector and code generator steering
   assign tone_bw_out     = tdec_reg[`SAT_TDEC_BW_MSB:0];
   assign tone_thr_out    = tdec_reg[`SAT_TDEC_THR_MSB:`SAT_TDEC_THR_LSB];
   assign wanted_tone_out = (sel_kind == sat_pkg::SAT_SEL_OFF) ? `SAT_SEL_ALL_CALL : sel;
   assign tone_learn_out  = mode_reg[`SAT_MODE_TONE_EN] && sel_kind == sat_pkg::SAT_SEL_LEARN;
   assign code_en_out     = mode_reg[`SAT_MODE_CODE_EN]
                            && (sel_kind == sat_pkg::SAT_SEL_CODE
                                || sel_kind == sat_pkg::SAT_SEL_CODE_INV);
   assign code_sel_out    = (sel_kind == sat_pkg::SAT_SEL_CODE_INV)
                            ? 8'(sel - `SAT_SEL_INV_FIRST + 8'h01) : sel;
   assign code_invert_out = sel_kind == sat_pkg::SAT_SEL_CODE_INV;
   assign code_24bit_out  = mode_reg[`SAT_MODE_CODE24];
   assign code_burst_out  = mode_reg[`SAT_MODE_CODE_EN] && mode_reg[`SAT_MODE_BURST];
   assign tone_phase_inv_out           = audio_reg[`SAT_AUD_PHASE];
   assign modulator_output_one_inv_out = mode_reg[`SAT_MODE_MOD_INV];
   assign modulator_output_two_inv_out = mode_reg[`SAT_MODE_MOD_INV];

endmodule : sat_audio_ctrl
`default_nettype wire

// file: dv/sat_audio_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "sat_regs.svh"
// watches the register port and the selection outputs derived from it
module sat_audio_ctrl_properties (
   input wire logic        core_clk_in,
   input wire logic        rst_b_in,
   input wire logic [7:0]  addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [15:0] rdata_out,
   input wire logic        sample_valid_in,
   input wire logic        audio_valid_out,
   input wire logic        phase_shift_in,
   input wire logic [3:0]  tone_bw_out,
   input wire logic [7:0]  tone_thr_out,
   input wire logic [7:0]  wanted_tone_out,
   input wire logic        tone_learn_out,
   input wire logic        code_en_out,
   input wire logic [7:0]  code_sel_out,
   input wire logic        modulator_output_one_inv_out,
   input wire logic        modulator_output_two_inv_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);

   // a selection write shows next cycle, zero standing for the all-call tone
   wanted_tone_a: assert property (
      wr_in && addr_in == `SAT_AUDIO_ADDR |=> wanted_tone_out ==
      ($past(wdata_in[7:0]) == 8'h00 ? 8'hf0 : $past(wdata_in[7:0])))
      else $error("wanted tone does not follow the selection");
   decoder_setup_a: assert property (
      wr_in && addr_in == `SAT_TDEC_ADDR |=> tone_bw_out == $past(wdata_in[3:0])
      && tone_thr_out == $past(wdata_in[11:4]))
      else $error("decoder setup fields not passed on");
   learn_mode_a: assert property (
      tone_learn_out |-> wanted_tone_out == `SAT_SEL_LEARN)
      else $error("learn mode without selection 200");
   code_range_a: assert property (
      code_en_out |-> wanted_tone_out inside {[8'h01:8'h54], [8'h65:8'hb8]})
      else $error("code enabled outside the code ranges");
   code_number_a: assert property (
      code_en_out |-> code_sel_out == (wanted_tone_out > 8'h64 ?
      wanted_tone_out - 8'h64 : wanted_tone_out))
      else $error("code number wrong");
   mod_invert_a: assert property (
      modulator_output_one_inv_out == modulator_output_two_inv_out)
      else $error("modulator inversions differ");
   sample_echo_a: assert property (
      sample_valid_in ##1 !sample_valid_in |-> audio_valid_out ##1 !audio_valid_out)
      else $error("audio valid does not follow the sample strobe");
   phase_tone_a: assert property (
      phase_shift_in ##1 (rd_in && addr_in == `SAT_TONE_ADDR)
      |=> rdata_out[`SAT_TONE_PHASE])
      else $error("phase flag missing in tone status");
   phase_status_a: assert property (
      phase_shift_in ##1 (rd_in && addr_in == `SAT_STAT_ADDR)
      |=> rdata_out[`SAT_STAT_TONE])
      else $error("phase shift missing in main status");

   // main scenarios reached
   cover property (tone_learn_out);
   cover property (code_en_out && code_sel_out == 8'h54);
   cover property (phase_shift_in ##1 (rd_in && addr_in == `SAT_TONE_ADDR));
endmodule : sat_audio_ctrl_properties
`default_nettype wire

// file: dv/sat_host_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "sat_regs.svh"
// host controller on the register port; strobes are one cycle wide
module sat_host_model (
   input  wire logic        core_clk_in,
   output logic      [7:0]  addr_out,
   output logic      [15:0] wdata_out,
   output logic             wr_out,
   output logic             rd_out,
   input  wire logic [15:0] rdata_in
);
   // bus idles with both strobes low
   initial begin
      addr_out = 8'h00;
      wdata_out = 16'h0000;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end

   // one-cycle write
   task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge core_clk_in);
      wr_out <= 1'b0;
   endtask : write_reg

   // one-cycle read, data taken in the following cycle only
   task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge core_clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge core_clk_in);
      rd_out <= 1'b0;
      #1;
      d = rdata_in;
   endtask : read_reg

   // reload the input gain, then switch into transmit
   task automatic start_tx(input logic [15:0] gain);
      write_reg(`SAT_GAIN_ADDR, gain);
      write_reg(`SAT_MODE_ADDR, 16'h0004);
   endtask : start_tx

   // narrowest decoder bandwidth before split tones may appear
   task automatic narrow_band;
      write_reg(`SAT_TDEC_ADDR, 16'h0101);
   endtask : narrow_band
endmodule : sat_host_model
`default_nettype wire

// file: dv/sat_audio_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "sat_regs.svh"
module sat_audio_ctrl_bench;
   logic        core_clk_in, rst_b_in, wr_in, rd_in, sample_valid_in, audio_valid_out;
   logic        tone_valid_in, phase_shift_in, tone_learn_out, code_en_out, code_invert_out;
   logic        code_24bit_out, code_burst_out, tone_phase_inv_out;
   logic        modulator_output_one_inv_out, modulator_output_two_inv_out;
   logic [3:0]  input_gain_out, tone_bw_out;
   logic [7:0]  addr_in, tone_rx_in, tone_thr_out, wanted_tone_out, code_sel_out;
   logic [15:0] wdata_in, rdata_out, gain_stage_in, preemph_in, rx_audio_in;
   logic [15:0] tx_audio_out, rx_audio_out, d;
   int          mismatches, n_compared;

   sat_audio_ctrl sat_audio_ctrl_i (.*);
   sat_host_model sat_host_model_i (
      .core_clk_in (core_clk_in),
      .addr_out    (addr_in),
      .wdata_out   (wdata_in),
      .wr_out      (wr_in),
      .rd_out      (rd_in),
      .rdata_in    (rdata_out)
   );

   // clock
   always #5 core_clk_in = ~core_clk_in;

   // compare and count
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      sat_host_model_i.write_reg(a, v);
      #1;
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, m, input string what);
      sat_host_model_i.read_reg(a, d);
      check(what, exp & m, d & m);
   endtask : rdchk

   // n audio sample strobes, one idle cycle apart
   task automatic samples(input int n);
      repeat (n) begin
         @(posedge core_clk_in) sample_valid_in <= 1'b1;
         @(posedge core_clk_in) sample_valid_in <= 1'b0;
      end
      @(posedge core_clk_in);
      #1;
   endtask : samples

   // detector event, then a register read in the very next cycle
   task automatic ev_read(input logic tv, input logic [7:0] rx, input logic ph, input logic [7:0] a);
      @(posedge core_clk_in);
      tone_valid_in <= tv;
      tone_rx_in <= rx;
      phase_shift_in <= ph;
      fork
         sat_host_model_i.read_reg(a, d);
         @(posedge core_clk_in) {tone_valid_in, phase_shift_in} <= 2'b00;
      join
   endtask : ev_read

   task automatic test_reset;
      for (int a = 0; a <= 32; a += 4) begin
         rdchk(a[7:0], (a == 12) ? `SAT_SCR_RESET : 16'h0000, 16'hffff, "reset value");
      end
      check("wanted tone", 16'h00f0, {8'h00, wanted_tone_out});
      wr(`SAT_SCR_ADDR, 16'h0bb8);
      rdchk(`SAT_SCR_ADDR, 16'h0bb8, 16'hffff, "scramble frequency");
      $display("reset test done");
   endtask : test_reset

   task automatic test_select;
      logic [7:0] s [0:11] = '{8'h00, 8'h01, 8'h53, 8'h54, 8'h65, 8'hb7, 8'hb8, 8'hc8,
                               8'hc9, 8'hf0, 8'hfe, 8'hff};
      logic       c;
      wr(`SAT_MODE_ADDR, 16'h0003);
      foreach (s[i]) begin
         c = (s[i] >= 8'h01 && s[i] <= 8'h54) || (s[i] >= 8'h65 && s[i] <= 8'hb8);
         wr(`SAT_AUDIO_ADDR, {8'h00, s[i]});
         check("wanted", {8'h00, (s[i] == 8'h00) ? 8'hf0 : s[i]}, {8'h00, wanted_tone_out});
         check("code enable", {15'h0000, c}, {15'h0000, code_en_out});
         check("learn", {15'h0000, s[i] == 8'hc8}, {15'h0000, tone_learn_out});
         if (c) check("code", {8'h00, (s[i] > 8'h64) ? s[i] - 8'h64 : s[i]}, {8'h00, code_sel_out});
      end
      $display("selection test done");
   endtask : test_select

   task automatic test_enables;
      wr(`SAT_AUDIO_ADDR, 16'h0105);
      wr(`SAT_MODE_ADDR, 16'h0000);
      check("code off", 16'h0000, {15'h0000, code_en_out});
      check("phase control", 16'h0001, {15'h0000, tone_phase_inv_out});
      wr(`SAT_MODE_ADDR, 16'h011a);
      check("code on", 16'h0085, {8'h00, code_en_out, 2'b00, code_sel_out[4:0]});
      check("options", 16'h0007, {13'h0000, code_24bit_out, code_burst_out,
                                  modulator_output_one_inv_out});
      rdchk(`SAT_AUDIO_ADDR, 16'h0005, 16'h00ff, "selection kept");
      $display("enable test done");
   endtask : test_enables

   task automatic test_tone;
      // selection, received tone, expected status, tone enable, detect flag
      logic [31:0] t [0:7] = '{32'hd5d5d511, 32'hd5f0f011, 32'hd5dcff10, 32'hd5000010,
                               32'h00f0f011, 32'h00d5ff10, 32'hc8cdcd11, 32'hd5d50000};
      sat_host_model_i.narrow_band();
      foreach (t[i]) begin
         wr(`SAT_MODE_ADDR, {15'h0000, t[i][4]});
         wr(`SAT_AUDIO_ADDR, {8'h00, t[i][31:24]});
         ev_read(1'b1, t[i][23:16], 1'b0, `SAT_TONE_ADDR);
         check("tone status", {8'h00, t[i][15:8]}, d & 16'h00ff);
         rdchk(`SAT_STAT_ADDR, {4'h0, t[i][0], 11'h000}, 16'h0800, "detect");
      end
      $display("tone test done");
   endtask : test_tone

   task automatic test_phase;
      wr(`SAT_MODE_ADDR, 16'h0001);
      ev_read(1'b0, 8'h00, 1'b1, `SAT_STAT_ADDR);
      check("phase status", 16'h0800, d & 16'h0800);
      ev_read(1'b0, 8'h00, 1'b1, `SAT_TONE_ADDR);
      check("phase flag", 16'h0200, d & 16'h0200);
      rdchk(`SAT_TONE_ADDR, 16'h0000, 16'h0200, "phase cleared");
      $display("phase test done");
   endtask : test_phase

   task automatic test_agc;
      @(posedge core_clk_in) gain_stage_in <= 16'h7fff;
      wr(`SAT_GAIN_ADDR, 16'h0005);
      wr(`SAT_MODE_ADDR, 16'h0004);
      samples(3);
      check("gain off", 16'h0005, {12'h000, input_gain_out});
      wr(`SAT_MODE_ADDR, 16'h0000);
      wr(`SAT_AGC_ADDR, 16'h1001);
      sat_host_model_i.start_tx(16'h0005);
      samples(3);
      check("gain down", 16'h0002, {12'h000, input_gain_out});
      samples(4);
      check("gain floor", 16'h0000, {12'h000, input_gain_out});
      @(posedge core_clk_in) gain_stage_in <= 16'h0000;
      samples(8);
      check("gain restored", 16'h0005, {12'h000, input_gain_out});
      wr(`SAT_AGC_ADDR, 16'h1011);
      @(posedge core_clk_in) gain_stage_in <= 16'h7fff;
      samples(4);
      @(posedge core_clk_in) gain_stage_in <= 16'h0000;
      samples(4);
      check("gain rate", 16'h0003, {12'h000, input_gain_out});
      wr(`SAT_AGC_ADDR, 16'h1003);
      @(posedge core_clk_in) gain_stage_in <= 16'h7fff;
      samples(4);
      rdchk(`SAT_GAIN_ADDR, 16'h0005, 16'h000f, "gain source");
      $display("gain control test done");
   endtask : test_agc

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   // reset, then the scenarios in turn
   initial begin
      {core_clk_in, rst_b_in, sample_valid_in, tone_valid_in, phase_shift_in} = 5'h00;
      {tone_rx_in, gain_stage_in, preemph_in, rx_audio_in} = 56'h0;
      mismatches = 0;
      n_compared = 0;
      repeat (12) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      test_reset();
      test_select();
      test_enables();
      test_tone();
      test_phase();
      test_agc();
      conclude();
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge core_clk_in);
      mismatches++;
      conclude();
   end
endmodule : sat_audio_ctrl_bench
bind sat_audio_ctrl sat_audio_ctrl_properties sat_audio_ctrl_properties_i (.*);
`default_nettype wire
